/* File: rtl/dsl_regs.vh */
// constants for the device status and lock flag bank
// Notes on behaviour
// - state field 001 diag, 010 active, 100 safe
// - restart disable set by 0xaa, cleared 0x55
// - restart latch survives reset unless battery lost
// - regulator overvoltage forces restart latch to one
// - latch zero restarts with wake high; else edge
// - config lock starts one, blocks config writes
// - config lock set: cmd in diag, exit, selftest
// - config lock cleared only by 0xaa in diag
// - selftest lock blocks selftest writes; set rules
// - control lock starts one; set rules apply
// - one clear command 0xaa clears both control locks
// - exit mask set 0x55, cleared 0xaa
// - mask clear allows diag timeout; set holds timer
// - safe timeout disable starts one; diag-only keys
// - disable zero: safe timeout expiry goes reset
// - in reset state responses read all zero
`ifndef DSL_REGS_VH
`define DSL_REGS_VH
`define DSL_KEY_55 8'h55
`define DSL_KEY_AA 8'haa
`define DSL_ST_NONE 3'h0
`define DSL_ST_DIAG 3'h1
`define DSL_ST_ACTIVE 3'h2
`define DSL_ST_SAFE 3'h4
`define DSL_ST_RESET 3'h3
`define DSL_ST_OFF 3'h5
`define DSL_CMD_NONE 4'h0
`define DSL_CMD_SET_RSTDIS 4'h1
`define DSL_CMD_CLR_RSTDIS 4'h2
`define DSL_CMD_SET_CFG 4'h3
`define DSL_CMD_CLR_CFG 4'h4
`define DSL_CMD_SET_CTRL 4'h5
`define DSL_CMD_CLR_CTRL 4'h6
`define DSL_CMD_MASK 4'h7
`define DSL_CMD_UNMASK 4'h8
`define DSL_CMD_DIS_STO 4'h9
`define DSL_CMD_EN_STO 4'ha
`define DSL_CMD_RD_STAT1 4'hb
`define DSL_CMD_RD_STAT2 4'hc
`define DSL_RST_RSTDIS 1'b0
`define DSL_RST_CFG 1'b1
`define DSL_RST_CTRL 1'b1
`define DSL_RST_BIST 1'b1
`define DSL_RST_MASK 1'b0
`define DSL_RST_STO 1'b1
`define DSL_DIAG_TO_CYC 16'h1000
`define DSL_SAFE_TO_CYC 16'h1000
`endif

/* File: rtl/dsl_sync.v */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module dsl_sync #(
	parameter W = 1
) (
	core_clk,
	rst,
	d,
	q
);
	input wire core_clk;
	input wire rst;
	input wire [W-1:0] d;
	output reg [W-1:0] q;
	reg [W-1:0] meta;
	always @(posedge core_clk) begin
		if (rst) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // dsl_sync

/* File: rtl/dsl_timer.v */
// time-out counter held in reset while not running
`timescale 1ns/1ps
module dsl_timer #(
	parameter W = 16
) (
	core_clk,
	rst,
	run,
	limit,
	expired
);
	input wire core_clk;
	input wire rst;
	input wire run;
	input wire [W-1:0] limit;
	output reg expired;
	reg [W-1:0] count;
	always @(posedge core_clk) begin
		if (rst || !run) begin
			count <= {W{1'b0}};
			expired <= 1'b0;
		end else if (count == limit - {{(W-1){1'b0}}, 1'b1}) begin
			expired <= 1'b1;
		end else begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // dsl_timer

/* File: rtl/dsl_status_bank.v */
// device status and lock flag bank with a small operating state machine
`include "dsl_regs.vh"
`timescale 1ns/1ps
module dsl_status_bank #(
	parameter DIAG_TO_CYC = `DSL_DIAG_TO_CYC,
	parameter SAFE_TO_CYC = `DSL_SAFE_TO_CYC
) (
	core_clk,
	rst,
	battery_lost,
	cmd_valid,
	cmd_code,
	cmd_data,
	go_active,
	go_safe,
	safe_exit,
	go_off,
	reset_done,
	regulator_ov,
	selftest_done,
	wake_pin,
	rsp_valid,
	rsp_data,
	operating_state_field,
	auto_restart_disable_latch,
	config_lock,
	selftest_ctrl_write_lock,
	control_lock,
	flag_a,
	safe_timeout_disable_flag,
	restart_req,
	config_write_blocked,
	selftest_write_blocked,
	control_write_blocked
);
	input wire core_clk;
	input wire rst;
	input wire battery_lost;
	input wire cmd_valid;
	input wire [3:0] cmd_code;
	input wire [7:0] cmd_data;
	input wire go_active;
	input wire go_safe;
	input wire safe_exit;
	input wire go_off;
	input wire reset_done;
	input wire regulator_ov;
	input wire selftest_done;
	input wire wake_pin;
	output reg rsp_valid;
	output reg [7:0] rsp_data;
	output reg [2:0] operating_state_field;
	output reg auto_restart_disable_latch;
	output reg config_lock;
	output reg selftest_ctrl_write_lock;
	output reg control_lock;
	output reg flag_a;
	output reg safe_timeout_disable_flag;
	output reg restart_req;
	output reg config_write_blocked;
	output reg selftest_write_blocked;
	output reg control_write_blocked;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function is_key;
		input [3:0] code;
		input [3:0] want;
		input [7:0] data;
		input [7:0] key;
		begin
			is_key = (code == want) && (data == key);
		end
	endfunction

	// internal state codes; the three visible ones equal the status field codes
	localparam [2:0] ST_DIAG = `DSL_ST_DIAG;
	localparam [2:0] ST_ACTIVE = `DSL_ST_ACTIVE;
	localparam [2:0] ST_SAFE = `DSL_ST_SAFE;
	localparam [2:0] ST_RESET = `DSL_ST_RESET;
	localparam [2:0] ST_OFF = `DSL_ST_OFF;

	wire wake_s;
	wire diag_expired;
	wire safe_expired;
	reg [2:0] state;
	reg [2:0] next_state;
	reg wake_d;
	reg rstdis_init;
	wire in_diag = (state == ST_DIAG);
	wire in_das = in_diag || (state == ST_ACTIVE) || (state == ST_SAFE);
	wire in_reset = (state == ST_RESET);
	// commands reach neither a resetting nor a powered-down core
	wire cv = cmd_valid && !in_reset && (state != ST_OFF);
	wire leave_diag = in_diag && (next_state != ST_DIAG);
	wire leave_das = in_das && (next_state != state);

	////////////////////////////////////////////////////////////////////////////
	// keyed command decode; state qualifiers sit here so set and clear agree
	wire set_restart_disable_cmd = cv &&
		is_key(cmd_code, `DSL_CMD_SET_RSTDIS, cmd_data, `DSL_KEY_AA);
	wire clear_restart_disable_cmd = cv &&
		is_key(cmd_code, `DSL_CMD_CLR_RSTDIS, cmd_data, `DSL_KEY_55);
	wire set_config_lock_cmd = cv && in_diag &&
		is_key(cmd_code, `DSL_CMD_SET_CFG, cmd_data, `DSL_KEY_55);
	wire clear_config_lock_cmd = cv && in_diag &&
		is_key(cmd_code, `DSL_CMD_CLR_CFG, cmd_data, `DSL_KEY_AA);
	wire set_control_lock_cmd = cv && in_das &&
		is_key(cmd_code, `DSL_CMD_SET_CTRL, cmd_data, `DSL_KEY_55);
	wire clear_control_lock_cmd = cv && in_das &&
		is_key(cmd_code, `DSL_CMD_CLR_CTRL, cmd_data, `DSL_KEY_AA);
	wire cmd_b = cv &&
		is_key(cmd_code, `DSL_CMD_MASK, cmd_data, `DSL_KEY_55);
	wire cmd_c = cv &&
		is_key(cmd_code, `DSL_CMD_UNMASK, cmd_data, `DSL_KEY_AA);
	wire disable_safe_timeout_cmd = cv && in_diag &&
		is_key(cmd_code, `DSL_CMD_DIS_STO, cmd_data, `DSL_KEY_55);
	wire enable_safe_timeout_cmd = cv && in_diag &&
		is_key(cmd_code, `DSL_CMD_EN_STO, cmd_data, `DSL_KEY_AA);

	dsl_sync #(.W(1)) u_wake (
		.core_clk(core_clk),
		.rst(rst),
		.d(wake_pin),
		.q(wake_s)
	);

	dsl_timer #(.W(16)) u_diag_to (
		.core_clk(core_clk),
		.rst(rst),
		.run(in_diag && !flag_a),
		.limit(DIAG_TO_CYC[15:0]),
		.expired(diag_expired)
	);

	dsl_timer #(.W(16)) u_safe_to (
		.core_clk(core_clk),
		.rst(rst),
		.run((state == `DSL_ST_SAFE) && !safe_timeout_disable_flag),
		.limit(SAFE_TO_CYC[15:0]),
		.expired(safe_expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// operating state
	always @* begin
		next_state = state;
		case (state)
		ST_DIAG: begin
			if (go_off)
				next_state = ST_OFF;
			else if ((diag_expired && !flag_a) || go_safe)
				next_state = ST_SAFE;
			else if (go_active)
				next_state = ST_ACTIVE;
		end
		ST_ACTIVE: begin
			if (go_off)
				next_state = ST_OFF;
			else if (go_safe)
				next_state = ST_SAFE;
		end
		ST_SAFE: begin
			if (go_off)
				next_state = ST_OFF;
			else if (safe_expired)
				next_state = ST_RESET;
			else if (safe_exit)
				next_state = ST_DIAG;
		end
		ST_RESET: begin
			if (go_off)
				next_state = ST_OFF;
			else if (reset_done)
				next_state = ST_DIAG;
		end
		ST_OFF: begin
			if (restart_req)
				next_state = ST_RESET;
		end
		default: next_state = ST_RESET;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			state <= ST_RESET;
			wake_d <= 1'b0;
			restart_req <= 1'b0;
			operating_state_field <= `DSL_ST_NONE;
		end else begin
			state <= next_state;
			wake_d <= wake_s;
			restart_req <= (next_state == `DSL_ST_OFF) &&
				(auto_restart_disable_latch ? (wake_s && !wake_d) : wake_s);
			if (next_state == `DSL_ST_DIAG || next_state == `DSL_ST_ACTIVE ||
				next_state == `DSL_ST_SAFE)
				operating_state_field <= next_state;
			else
				operating_state_field <= `DSL_ST_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// restart disable latch; battery_lost is sampled on every clock edge while rst is held
	// because the latch itself may not load a port value under reset
	always @(posedge core_clk) begin
		if (rst) begin
			rstdis_init <= 1'b1;
		end else begin
			rstdis_init <= 1'b0;
		end
	end

	reg batt_seen;
	always @(posedge core_clk) begin
		if (rst) begin
			if (battery_lost)
				batt_seen <= 1'b1;
		end else if (!rstdis_init) begin
			batt_seen <= 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (regulator_ov) begin
			auto_restart_disable_latch <= 1'b1;
		end else if (rstdis_init && batt_seen) begin
			auto_restart_disable_latch <= `DSL_RST_RSTDIS;
		end else if (!rst && set_restart_disable_cmd) begin
			auto_restart_disable_latch <= 1'b1;
		end else if (!rst && clear_restart_disable_cmd) begin
			auto_restart_disable_latch <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock, mask and time-out flags; set wins over clear
	always @(posedge core_clk) begin
		if (rst) begin
			config_lock <= `DSL_RST_CFG;
			control_lock <= `DSL_RST_CTRL;
			selftest_ctrl_write_lock <= `DSL_RST_BIST;
			flag_a <= `DSL_RST_MASK;
			safe_timeout_disable_flag <= `DSL_RST_STO;
		end else begin
			if (set_config_lock_cmd ||
				leave_diag || selftest_done)
				config_lock <= 1'b1;
			else if (clear_config_lock_cmd)
				config_lock <= 1'b0;
			if (set_control_lock_cmd ||
				leave_diag || selftest_done)
				control_lock <= 1'b1;
			else if (clear_control_lock_cmd)
				control_lock <= 1'b0;
			if (set_control_lock_cmd ||
				leave_das || selftest_done)
				selftest_ctrl_write_lock <= 1'b1;
			else if (clear_control_lock_cmd)
				selftest_ctrl_write_lock <= 1'b0;
			if (cmd_b)
				flag_a <= 1'b1;
			else if (cmd_c)
				flag_a <= 1'b0;
			if (disable_safe_timeout_cmd)
				safe_timeout_disable_flag <= 1'b1;
			else if (enable_safe_timeout_cmd)
				safe_timeout_disable_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write blocking and command response
	always @(posedge core_clk) begin
		if (rst) begin
			config_write_blocked <= 1'b1;
			selftest_write_blocked <= 1'b1;
			control_write_blocked <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			config_write_blocked <= config_lock || !in_diag;
			selftest_write_blocked <= selftest_ctrl_write_lock;
			control_write_blocked <= control_lock;
			rsp_valid <= cmd_valid;
			if (!cv)
				rsp_data <= 8'h00;
			else if (cmd_code == `DSL_CMD_RD_STAT1)
				rsp_data <= {operating_state_field, 1'b0, auto_restart_disable_latch,
					config_lock, selftest_ctrl_write_lock, control_lock};
			else if (cmd_code == `DSL_CMD_RD_STAT2)
				rsp_data <= {1'b0, flag_a, safe_timeout_disable_flag, 5'h00};
			else
				rsp_data <= 8'h00;
		end
	end
endmodule // dsl_status_bank

/* File: testbench/dsl_status_bank_props.sv */
// concurrent checks on the status and lock flag bank ports
`include "dsl_regs.vh"
`timescale 1ns/1ps
module dsl_status_bank_props (
	input wire core_clk,
	input wire rst,
	input wire cmd_valid,
	input wire [3:0] cmd_code,
	input wire [7:0] cmd_data,
	input wire go_safe,
	input wire regulator_ov,
	input wire selftest_done,
	input wire [7:0] rsp_data,
	input wire [2:0] operating_state_field,
	input wire auto_restart_disable_latch,
	input wire config_lock,
	input wire selftest_ctrl_write_lock,
	input wire control_lock,
	input wire flag_a,
	input wire safe_timeout_disable_flag
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire [2:0] st = operating_state_field;
	wire diag = st == `DSL_ST_DIAG;
	// field reads 000 in the reset state, so commands there are never taken
	wire live = st != `DSL_ST_NONE;
	wire key_aa = cmd_valid && cmd_data == `DSL_KEY_AA;
	wire key_55 = cmd_valid && cmd_data == `DSL_KEY_55;
	wire clr_cfg_ok = key_aa && cmd_code == `DSL_CMD_CLR_CFG && diag;
	wire clr_ctrl_ok = key_aa && cmd_code == `DSL_CMD_CLR_CTRL && live;
	wire mask_ok = key_55 && cmd_code == `DSL_CMD_MASK && live;
	wire dis_ok = key_55 && cmd_code == `DSL_CMD_DIS_STO;
	wire sto_ok = diag && (dis_ok || key_aa && cmd_code == `DSL_CMD_EN_STO);
	state_code_a: assert property ($onehot0(st)) else $error("bad state code");
	restart_set_a: assert property (
		key_aa && cmd_code == `DSL_CMD_SET_RSTDIS && live |=> auto_restart_disable_latch)
		else $error("restart latch not set");
	restart_clr_a: assert property (
		key_55 && cmd_code == `DSL_CMD_CLR_RSTDIS && live && !regulator_ov
		|=> !auto_restart_disable_latch) else $error("restart latch not cleared");
	ov_forces_a: assert property (
		regulator_ov |-> ##[1:4] auto_restart_disable_latch) else $error("ov did not set latch");
	cfg_clear_a: assert property (
		$fell(config_lock) |-> $past(clr_cfg_ok)) else $error("config lock cleared wrongly");
	ctrl_clear_a: assert property (
		$fell(control_lock) || $fell(selftest_ctrl_write_lock) |-> $past(clr_ctrl_ok))
		else $error("control lock cleared wrongly");
	mask_set_a: assert property (
		$rose(flag_a) |-> $past(mask_ok)) else $error("exit mask set wrongly");
	sto_change_a: assert property (
		$changed(safe_timeout_disable_flag) |-> $past(sto_ok)) else $error("timeout flag moved");
	selftest_set_a: assert property (
		selftest_done |=> config_lock && control_lock && selftest_ctrl_write_lock)
		else $error("selftest did not lock");
	diag_hold_a: assert property (
		diag && flag_a && !go_safe |=> st != `DSL_ST_SAFE) else $error("masked diag left");
	rsp_reset_a: assert property (
		cmd_valid && !live |=> rsp_data == 8'h00) else $error("reset response not zero");
	cover property (clr_cfg_ok);
	cover property ($fell(selftest_ctrl_write_lock));
	cover property (st == `DSL_ST_SAFE ##1 st == `DSL_ST_NONE);
endmodule // dsl_status_bank_props
bind dsl_status_bank dsl_status_bank_props u_dsl_status_bank_props (.core_clk(core_clk),
	.rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
	.go_safe(go_safe), .regulator_ov(regulator_ov), .selftest_done(selftest_done),
	.rsp_data(rsp_data), .operating_state_field(operating_state_field),
	.auto_restart_disable_latch(auto_restart_disable_latch), .config_lock(config_lock),
	.selftest_ctrl_write_lock(selftest_ctrl_write_lock), .control_lock(control_lock),
	.flag_a(flag_a), .safe_timeout_disable_flag(safe_timeout_disable_flag));

/* File: testbench/dsl_mcu_model.sv */
// controller side model issuing one keyed command at a time
`timescale 1ns/1ps
module dsl_mcu_model (
	input wire core_clk,
	output logic cmd_valid,
	output logic [3:0] cmd_code,
	output logic [7:0] cmd_data,
	input wire [7:0] rsp_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_data = 8'h00;
	end
	// key byte travels with its code in the same cycle
	task automatic send(input logic [3:0] code, input logic [7:0] data, output logic [7:0] rsp);
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_data = data;
		@(posedge core_clk);
		#1;
		rsp = rsp_data;
		cmd_valid = 1'b0;
		// stale key is inverted so nothing can lean on the old byte
		cmd_code = ~code;
		cmd_data = ~data;
	endtask
endmodule // dsl_mcu_model

/* File: testbench/dsl_status_bank_bench.sv */
// self-checking bench for the status and lock flag bank
`include "dsl_regs.vh"
`timescale 1ns/1ps
module dsl_status_bank_bench;
	logic core_clk, rst, battery_lost, go_active, go_safe, safe_exit, go_off, reset_done;
	logic regulator_ov, selftest_done, wake_pin;
	logic [7:0] rsp;
	int n_fail = 0;
	int comparisons = 0;
	wire cmd_valid, rsp_valid, rstdis, cfg, bist, ctrl, mask, sto;
	wire [3:0] cmd_code;
	wire [7:0] cmd_data, rsp_data;
	wire [2:0] st;
	wire rreq, cfg_blk, bist_blk, ctrl_blk;
	wire [7:0] blk = {5'h00, cfg_blk, bist_blk, ctrl_blk};
	wire [7:0] flags = {2'b00, rstdis, cfg, bist, ctrl, mask, sto};
	dsl_status_bank #(.DIAG_TO_CYC(16'h0010), .SAFE_TO_CYC(16'h0010)) u_dsl_status_bank (
		.core_clk(core_clk), .rst(rst), .battery_lost(battery_lost), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .go_active(go_active), .go_safe(go_safe),
		.safe_exit(safe_exit), .go_off(go_off), .reset_done(reset_done),
		.regulator_ov(regulator_ov), .selftest_done(selftest_done), .wake_pin(wake_pin),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .operating_state_field(st),
		.auto_restart_disable_latch(rstdis), .config_lock(cfg), .selftest_ctrl_write_lock(bist),
		.control_lock(ctrl), .flag_a(mask), .safe_timeout_disable_flag(sto), .restart_req(rreq),
		.config_write_blocked(cfg_blk), .selftest_write_blocked(bist_blk),
		.control_write_blocked(ctrl_blk));
	dsl_mcu_model u_dsl_mcu_model (.core_clk(core_clk), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_data(rsp_data));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic test_done();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [3:0] code, input logic [7:0] data);
		u_dsl_mcu_model.send(code, data, rsp);
	endtask
	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#1 s = 1'b1;
		@(posedge core_clk);
		#1 s = 1'b0;
	endtask
	task automatic wait_state(input logic [2:0] want);
		int i;
		for (i = 0; i < 200 && st !== want; i++) begin
			@(posedge core_clk);
			#1;
		end
		comparisons++;
		if (i == 200) begin
			n_fail++;
			$display("[ERR] %0t state wait ran out", $time);
			test_done();
		end
	endtask
	task automatic do_reset(input logic lost);
		@(posedge core_clk);
		#1 rst = 1'b1;
		battery_lost = lost;
		repeat (20) @(posedge core_clk);
		#1 rst = 1'b0;
		battery_lost = 1'b0;
	endtask
	initial begin
		{rst, battery_lost, go_active, go_safe, safe_exit, go_off, reset_done} = 7'h7f & 7'h60;
		{regulator_ov, selftest_done, wake_pin} = 3'h0;
		do_reset(1'b1);
		cmd(`DSL_CMD_RD_STAT1, 8'h00);
		chk(rsp, 8'h00);
		chk({7'h00, rsp_valid}, 8'h01);
		chk(flags, 8'h1d);
		chk(blk, 8'h07);
		pulse(reset_done);
		cmd(`DSL_CMD_MASK, 8'haa);
		chk(flags, 8'h1d);
		cmd(`DSL_CMD_MASK, `DSL_KEY_55);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_RD_STAT1, 8'h00);
		chk(rsp, 8'h27);
		cmd(`DSL_CMD_RD_STAT2, 8'h00);
		chk(rsp, 8'h60);
		cmd(`DSL_CMD_SET_RSTDIS, `DSL_KEY_55);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_SET_RSTDIS, `DSL_KEY_AA);
		chk(flags, 8'h3f);
		cmd(`DSL_CMD_CLR_RSTDIS, `DSL_KEY_55);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_CLR_CFG, `DSL_KEY_55);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_CLR_CFG, `DSL_KEY_AA);
		cmd(`DSL_CMD_CLR_CTRL, `DSL_KEY_AA);
		chk(flags, 8'h03);
		@(posedge core_clk);
		#1 chk(blk, 8'h00);
		pulse(selftest_done);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_CLR_CTRL, `DSL_KEY_AA);
		cmd(`DSL_CMD_SET_CTRL, `DSL_KEY_55);
		chk(flags, 8'h1f);
		cmd(`DSL_CMD_CLR_CFG, `DSL_KEY_AA);
		cmd(`DSL_CMD_CLR_CTRL, `DSL_KEY_AA);
		pulse(go_active);
		wait_state(`DSL_ST_ACTIVE);
		cmd(`DSL_CMD_RD_STAT1, 8'h00);
		chk(rsp, 8'h47);
		cmd(`DSL_CMD_CLR_CFG, `DSL_KEY_AA);
		cmd(`DSL_CMD_EN_STO, `DSL_KEY_AA);
		cmd(`DSL_CMD_CLR_CTRL, `DSL_KEY_AA);
		chk(flags, 8'h13);
		@(posedge core_clk);
		#1 chk(blk, 8'h04);
		pulse(go_safe);
		wait_state(`DSL_ST_SAFE);
		pulse(regulator_ov);
		cmd(`DSL_CMD_RD_STAT1, 8'h00);
		chk(rsp, 8'h8e);
		pulse(safe_exit);
		wait_state(`DSL_ST_DIAG);
		cmd(`DSL_CMD_UNMASK, `DSL_KEY_AA);
		cmd(`DSL_CMD_EN_STO, `DSL_KEY_AA);
		chk(flags, 8'h38);
		wait_state(`DSL_ST_SAFE);
		wait_state(`DSL_ST_NONE);
		cmd(`DSL_CMD_RD_STAT2, 8'h00);
		chk(rsp, 8'h00);
		do_reset(1'b0);
		chk(flags, 8'h3d);
		// latch is one here: a steady high wake must not restart from off
		wake_pin = 1'b1;
		pulse(reset_done);
		pulse(go_off);
		chk({7'h00, rreq}, 8'h00);
		pulse(reset_done);
		chk({5'h00, st}, 8'h00);
		wake_pin = 1'b0;
		repeat (4) @(posedge core_clk);
		#1 wake_pin = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk({7'h00, rreq}, 8'h01);
		pulse(reset_done);
		wait_state(`DSL_ST_DIAG);
		cmd(`DSL_CMD_CLR_RSTDIS, `DSL_KEY_55);
		pulse(go_off);
		chk({7'h00, rreq}, 8'h01);
		pulse(reset_done);
		wait_state(`DSL_ST_DIAG);
		test_done();
	end
endmodule // dsl_status_bank_bench
